// ==== include/ccr_map.svh ====
// Offsets, field positions, reset values and timing counts of the bank
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH
`define CCR_ADDR_W 11
`define CCR_BASE_ADDR 11'h200
`define CCR_COR_ADDR 11'h200
`define CCR_CCSR_ADDR 11'h202
`define CCR_PRR_ADDR 11'h204
`define CCR_COR_RESET 8'h00
`define CCR_CCSR_RESET 8'h00
`define CCR_PRR_RESET 8'h0c
`define CCR_COR_SOFT_RESET_BIT 7
`define CCR_COR_LEVIRQ 6
`define CCR_CCSR_CHANGED 7
`define CCR_CCSR_STATUS_CHANGE_ENABLE 6
`define CCR_CCSR_IO8 5
`define CCR_CCSR_PWRDN 2
`define CCR_CCSR_INT 1
`define CCR_PRR_CRDY 5
`define CCR_PRR_CWP 4
`define CCR_PRR_RRDY 1
`define CCR_PRR_WP 0
`define CCR_PRR_FIXED 8'h0c
`define CCR_IDX_MEM 6'h00
`define CCR_IDX_CONTIG 6'h01
`define CCR_IDX_PRIMARY 6'h02
`define CCR_IDX_SECONDARY 6'h03
`define CCR_CLK_NS 25
`define CCR_PWR_SETTLE_NS 1000
`define CCR_PWR_SETTLE_CYC ((`CCR_PWR_SETTLE_NS + `CCR_CLK_NS - 1) / `CCR_CLK_NS)
`define CCR_IRQ_PULSE_NS 500
`define CCR_IRQ_PULSE_CYC ((`CCR_IRQ_PULSE_NS + `CCR_CLK_NS - 1) / `CCR_CLK_NS)
`endif

// ==== include/ccr_pkg.sv ====
// Types shared by the configuration bank modules
package ccr_pkg;
    typedef enum logic [4:0] {
        CCR_MODE_MEM = 5'b00001,
        CCR_MODE_CONTIG = 5'b00010,
        CCR_MODE_PRIMARY = 5'b00100,
        CCR_MODE_SECONDARY = 5'b01000,
        CCR_MODE_NONE = 5'b10000
    } ccr_mode_t;
    typedef enum logic [3:0] {
        CCR_PWR_ACTIVE = 4'b0001,
        CCR_PWR_ENTER = 4'b0010,
        CCR_PWR_SAVE = 4'b0100,
        CCR_PWR_WAKE = 4'b1000
    } ccr_pwr_t;
endpackage

// ==== include/ccr_if.sv ====
// Internal carrier between the bank and its decode and power modules
`timescale 1ns/10ps
interface ccr_if;
    logic [5:0] config_index;
    logic [10:0] io_addr;
    ccr_pkg::ccr_mode_t mode;
    logic tf_hit;
    logic [3:0] tf_index;
    logic power_save_request;
    logic power_req_change;
    logic card_reset;
    logic idle;
    logic command;
    logic power_save;
    logic power_busy;
    modport ctrl (output config_index, io_addr, power_save_request,
        power_req_change, card_reset, idle, command,
        input mode, tf_hit, tf_index, power_save, power_busy);
    modport dec (input config_index, io_addr,
        output mode, tf_hit, tf_index);
    modport pwr (input power_save_request, power_req_change, card_reset,
        idle, command, output power_save, power_busy);
endinterface

// ==== rtl/ccr_decode.sv ====
// Mapping mode and task-file address decode from the configuration index
`timescale 1ns/10ps
`include "ccr_map.svh"
module ccr_decode (
    ccr_if.dec bus
);
    function automatic logic in_range(input logic [10:0] a,
        input logic [10:0] lo, input logic [10:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    always_comb begin
        bus.tf_hit = 1'b0;
        bus.tf_index = bus.io_addr[3:0];
        case (bus.config_index)
            `CCR_IDX_MEM: begin
                bus.mode = ccr_pkg::CCR_MODE_MEM;
                bus.tf_hit = in_range(bus.io_addr, 11'h000, 11'h00f) ||
                    in_range(bus.io_addr, 11'h400, 11'h7ff);
            end
            `CCR_IDX_CONTIG: begin
                bus.mode = ccr_pkg::CCR_MODE_CONTIG;
                bus.tf_hit = 1'b1;
            end
            `CCR_IDX_PRIMARY: begin
                bus.mode = ccr_pkg::CCR_MODE_PRIMARY;
                if (in_range(bus.io_addr, 11'h1f0, 11'h1f7)) begin
                    bus.tf_hit = 1'b1;
                    bus.tf_index = {1'b0, bus.io_addr[2:0]};
                end else if (in_range(bus.io_addr, 11'h3f6, 11'h3f7)) begin
                    bus.tf_hit = 1'b1;
                    bus.tf_index = {3'h7, bus.io_addr[0]};
                end
            end
            `CCR_IDX_SECONDARY: begin
                bus.mode = ccr_pkg::CCR_MODE_SECONDARY;
                if (in_range(bus.io_addr, 11'h170, 11'h177)) begin
                    bus.tf_hit = 1'b1;
                    bus.tf_index = {1'b0, bus.io_addr[2:0]};
                end else if (in_range(bus.io_addr, 11'h376, 11'h377)) begin
                    bus.tf_hit = 1'b1;
                    bus.tf_index = {3'h7, bus.io_addr[0]};
                end
            end
            default: begin
                bus.mode = ccr_pkg::CCR_MODE_NONE;
            end
        endcase
    end
endmodule // ccr_decode

// ==== rtl/ccr_power.sv ====
// Power-saving state tracker with busy while a transition settles
`timescale 1ns/10ps
`include "ccr_map.svh"
module ccr_power #(
    parameter int SETTLE_CYC = `CCR_PWR_SETTLE_CYC
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // Control
    ccr_if.pwr bus
);
    ccr_pkg::ccr_pwr_t state, next_state;
    logic [15:0] count, next_count;
    logic want_save;

    always_comb begin
        next_state = state;
        next_count = (count != 16'h0000) ? count - 16'h0001 : 16'h0000;
        // Host bit or idle requests saving; a command masks both requests
        want_save = (bus.power_save_request | bus.idle) & ~bus.command;
        case (state)
            ccr_pkg::CCR_PWR_ACTIVE: begin
                if (want_save) begin
                    next_state = ccr_pkg::CCR_PWR_ENTER;
                    next_count = 16'(SETTLE_CYC);
                end
            end
            ccr_pkg::CCR_PWR_ENTER: begin
                if (count == 16'h0001) begin
                    next_state = ccr_pkg::CCR_PWR_SAVE;
                end
            end
            ccr_pkg::CCR_PWR_SAVE: begin
                if (!want_save) begin
                    next_state = ccr_pkg::CCR_PWR_WAKE;
                    next_count = 16'(SETTLE_CYC);
                end
            end
            ccr_pkg::CCR_PWR_WAKE: begin
                if (count == 16'h0001) begin
                    next_state = ccr_pkg::CCR_PWR_ACTIVE;
                end
            end
            default: begin
                next_state = ccr_pkg::CCR_PWR_ACTIVE;
            end
        endcase
        if (bus.card_reset) begin
            next_state = ccr_pkg::CCR_PWR_ACTIVE;
            next_count = 16'h0000;
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            state <= ccr_pkg::CCR_PWR_ACTIVE;
            count <= 16'h0000;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    assign bus.power_save = (state == ccr_pkg::CCR_PWR_SAVE);
    // Busy while settling or in the cycle the request bit changes
    assign bus.power_busy = (state == ccr_pkg::CCR_PWR_ENTER) ||
        (state == ccr_pkg::CCR_PWR_WAKE) || bus.power_req_change;
endmodule // ccr_power

// ==== rtl/ccr_bank.sv ====
// Card configuration register bank reached through attribute memory
`timescale 1ns/10ps
`include "ccr_map.svh"
module ccr_bank #(
    parameter int SETTLE_CYC = `CCR_PWR_SETTLE_CYC,
    parameter int IRQ_PULSE_CYC = `CCR_IRQ_PULSE_CYC
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // Attribute memory access
    input wire logic reg_select_n_in,
    input wire logic card_enable_n_in,
    input wire logic output_enable_n_in,
    input wire logic write_enable_n_in,
    input wire logic [10:0] addr_in,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_out,
    // Card core status
    input wire logic ready_in,
    input wire logic irq_request_in,
    input wire logic irq_disable_bit_in,
    input wire logic idle_in,
    input wire logic command_in,
    // Task-file decode
    input wire logic [10:0] io_addr_in,
    output logic taskfile_hit_out,
    output logic [3:0] taskfile_index_out,
    output logic io_mode_out,
    // Card control and host lines
    output logic card_reset_out,
    output logic power_save_out,
    output logic status_change_line_n_out,
    output logic host_irq_line_n_out
);
    ccr_if link ();

    // Register state
    logic soft_reset_bit, next_soft_reset_bit;
    logic level_irq_select, next_level_irq_select;
    logic [5:0] config_index, next_config_index;
    logic status_change_enable, next_status_change_enable;
    logic byte_io_request, next_byte_io_request;
    logic power_save_request, next_power_save_request;
    logic ready_changed, next_ready_changed;
    logic write_protect_changed, next_write_protect_changed;
    logic ready_state_q, next_ready_state_q;
    logic we_n_q, next_we_n_q;
    logic power_req_change, next_power_req_change;
    // Output state
    logic [7:0] next_data_out;
    logic next_data_oe_out;
    logic next_taskfile_hit_out;
    logic [3:0] next_taskfile_index_out;
    logic next_io_mode_out;
    logic next_card_reset_out;
    logic next_power_save_out;
    logic next_status_change_line_n_out;
    logic next_host_irq_line_n_out;
    logic irq_q, next_irq_q;
    logic [15:0] pulse_count, next_pulse_count;
    // Derived
    logic io_mode;
    logic ready_state;
    logic write_protect_state;
    logic changed;
    logic irq_pending;
    logic [7:0] cor_rd, ccsr_rd, prr_rd;
    logic wr_strobe;
    logic [1:0] wr_sel;
    logic wr_hit;
    logic [2:0] reg_sel;

    // Attribute register select: returns index and hit for an address
    function automatic logic [2:0] reg_decode(input logic [10:0] a);
        reg_decode = 3'b000;
        if (a == `CCR_COR_ADDR) begin
            reg_decode = 3'b100;
        end else if (a == `CCR_CCSR_ADDR) begin
            reg_decode = 3'b101;
        end else if (a == `CCR_PRR_ADDR) begin
            reg_decode = 3'b110;
        end
    endfunction

    ccr_decode u_decode (
        .bus(link.dec)
    );

    ccr_power #(
        .SETTLE_CYC(SETTLE_CYC)
    ) u_power (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .bus(link.pwr)
    );

    assign link.config_index = config_index;
    assign link.io_addr = io_addr_in;
    assign link.power_save_request = power_save_request;
    assign link.power_req_change = power_req_change;
    assign link.card_reset = soft_reset_bit;
    assign link.idle = idle_in;
    assign link.command = command_in;

    // Status derived from mode and core
    always_comb begin
        io_mode = (link.mode != ccr_pkg::CCR_MODE_MEM) &&
            (link.mode != ccr_pkg::CCR_MODE_NONE);
        irq_pending = irq_request_in & ~irq_disable_bit_in;
        ready_state = io_mode ? irq_pending :
            (ready_in & ~link.power_busy);
        write_protect_state = 1'b0;
        changed = ready_changed | write_protect_changed;
        cor_rd = {soft_reset_bit, level_irq_select, config_index};
        ccsr_rd = {changed, status_change_enable, byte_io_request, 2'b00,
            power_save_request, irq_pending, 1'b0};
        prr_rd = `CCR_PRR_FIXED | {2'b00, ready_changed,
            write_protect_changed, 2'b00, ready_state,
            write_protect_state};
    end

    // Write taken as write enable rises on an even selected byte
    always_comb begin
        reg_sel = reg_decode(addr_in);
        wr_strobe = ~we_n_q & write_enable_n_in & ~reg_select_n_in &
            ~card_enable_n_in & ~addr_in[0];
        wr_hit = wr_strobe & reg_sel[2];
        wr_sel = reg_sel[1:0];
    end

    // Register next values
    always_comb begin
        next_soft_reset_bit = soft_reset_bit;
        next_level_irq_select = level_irq_select;
        next_config_index = config_index;
        next_status_change_enable = status_change_enable;
        next_byte_io_request = byte_io_request;
        next_power_save_request = power_save_request;
        next_ready_changed = ready_changed;
        next_write_protect_changed = write_protect_changed;
        next_ready_state_q = ready_state;
        next_we_n_q = write_enable_n_in;
        next_power_req_change = 1'b0;
        if (wr_hit) begin
            case (wr_sel)
                2'b00: begin
                    next_soft_reset_bit = data_in[`CCR_COR_SOFT_RESET_BIT];
                    next_level_irq_select = data_in[`CCR_COR_LEVIRQ];
                    next_config_index = data_in[5:0];
                end
                2'b01: begin
                    next_status_change_enable =
                        data_in[`CCR_CCSR_STATUS_CHANGE_ENABLE];
                    next_byte_io_request = data_in[`CCR_CCSR_IO8];
                    next_power_save_request = data_in[`CCR_CCSR_PWRDN];
                    next_power_req_change = data_in[`CCR_CCSR_PWRDN] !=
                        power_save_request;
                end
                2'b10: begin
                    if (data_in[`CCR_PRR_RRDY]) begin
                        next_ready_changed = data_in[`CCR_PRR_CRDY];
                    end
                    if (data_in[`CCR_PRR_WP]) begin
                        next_write_protect_changed =
                            data_in[`CCR_PRR_CWP];
                    end
                end
                default: begin
                end
            endcase
        end
        // Hardware events win over a host clear in the same cycle
        if (ready_state != ready_state_q) begin
            next_ready_changed = 1'b1;
        end
        if (write_protect_state != 1'b0) begin
            next_write_protect_changed = 1'b1;
        end
        // Soft reset holds everything but itself, ready_state_q and we_n_q at reset values
        if (soft_reset_bit) begin
            next_level_irq_select = 1'b0;
            next_config_index = `CCR_IDX_MEM;
            next_status_change_enable = 1'b0;
            next_byte_io_request = 1'b0;
            next_power_save_request = 1'b0;
            next_power_req_change = 1'b0;
            next_ready_changed = 1'b0;
            next_write_protect_changed = 1'b0;
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            soft_reset_bit <= 1'b0;
            level_irq_select <= 1'b0;
            config_index <= 6'h00;
            status_change_enable <= 1'b0;
            byte_io_request <= 1'b0;
            power_save_request <= 1'b0;
            ready_changed <= 1'b0;
            write_protect_changed <= 1'b0;
            ready_state_q <= 1'b0;
            we_n_q <= 1'b1;
            power_req_change <= 1'b0;
        end else begin
            soft_reset_bit <= next_soft_reset_bit;
            level_irq_select <= next_level_irq_select;
            config_index <= next_config_index;
            status_change_enable <= next_status_change_enable;
            byte_io_request <= next_byte_io_request;
            power_save_request <= next_power_save_request;
            ready_changed <= next_ready_changed;
            write_protect_changed <= next_write_protect_changed;
            ready_state_q <= next_ready_state_q;
            we_n_q <= next_we_n_q;
            power_req_change <= next_power_req_change;
        end
    end

    // Output next values
    always_comb begin
        next_data_out = 8'h00;
        next_data_oe_out = 1'b0;
        if (~reg_select_n_in & ~card_enable_n_in & ~output_enable_n_in &
            write_enable_n_in & ~addr_in[0] &
            reg_sel[2]) begin
            next_data_oe_out = 1'b1;
            case (reg_sel[1:0])
                2'b00: next_data_out = cor_rd;
                2'b01: next_data_out = ccsr_rd;
                2'b10: next_data_out = prr_rd;
                default: next_data_out = 8'h00;
            endcase
        end
        next_taskfile_hit_out = link.tf_hit;
        next_taskfile_index_out = link.tf_index;
        next_io_mode_out = io_mode;
        next_card_reset_out = soft_reset_bit;
        next_power_save_out = link.power_save;
        next_status_change_line_n_out = 1'b1;
        if (io_mode && status_change_enable && changed) begin
            next_status_change_line_n_out = 1'b0;
        end
        next_irq_q = irq_pending;
        next_pulse_count = (pulse_count != 16'h0000) ?
            pulse_count - 16'h0001 : 16'h0000;
        if (irq_pending && !irq_q) begin
            next_pulse_count = 16'(IRQ_PULSE_CYC);
        end
        next_host_irq_line_n_out = 1'b1;
        if (io_mode) begin
            next_host_irq_line_n_out = level_irq_select ? ~irq_pending :
                (next_pulse_count == 16'h0000);
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            data_out <= 8'h00;
            data_oe_out <= 1'b0;
            taskfile_hit_out <= 1'b0;
            taskfile_index_out <= 4'h0;
            io_mode_out <= 1'b0;
            card_reset_out <= 1'b0;
            power_save_out <= 1'b0;
            status_change_line_n_out <= 1'b1;
            host_irq_line_n_out <= 1'b1;
            irq_q <= 1'b0;
            pulse_count <= 16'h0000;
        end else begin
            data_out <= next_data_out;
            data_oe_out <= next_data_oe_out;
            taskfile_hit_out <= next_taskfile_hit_out;
            taskfile_index_out <= next_taskfile_index_out;
            io_mode_out <= next_io_mode_out;
            card_reset_out <= next_card_reset_out;
            power_save_out <= next_power_save_out;
            status_change_line_n_out <= next_status_change_line_n_out;
            host_irq_line_n_out <= next_host_irq_line_n_out;
            irq_q <= next_irq_q;
            pulse_count <= next_pulse_count;
        end
    end
endmodule // ccr_bank

// ==== tb/ccr_host_model.sv ====
// Host socket model that runs attribute memory byte cycles
`timescale 1ns/10ps
module ccr_host_model (
    // Clock
    input wire logic clock_in,
    // Attribute bus
    output logic reg_select_n_out,
    output logic card_enable_n_out,
    output logic output_enable_n_out,
    output logic write_enable_n_out,
    output logic [10:0] addr_out,
    output logic [7:0] data_out,
    input wire logic [7:0] rdata_in,
    input wire logic rdata_oe_in
);
    initial begin
        {reg_select_n_out, card_enable_n_out} = 2'b11;
        {output_enable_n_out, write_enable_n_out} = 2'b11;
        addr_out = 11'h000;
        data_out = 8'h00;
    end
    // Even byte cycles, select held to the sampling edge
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        @(posedge clock_in);
        #1;
        {reg_select_n_out, card_enable_n_out, write_enable_n_out} = 3'b000;
        addr_out = a;
        data_out = d;
        @(posedge clock_in);
        #1;
        write_enable_n_out = 1'b1;
        @(posedge clock_in);
        #1;
        {reg_select_n_out, card_enable_n_out} = 2'b11;
        data_out = ~d;
    endtask
    task automatic rd(input logic [10:0] a, output logic [7:0] d,
        output logic oe);
        @(posedge clock_in);
        #1;
        {reg_select_n_out, card_enable_n_out, output_enable_n_out} = 3'b000;
        addr_out = a;
        repeat (2) @(posedge clock_in);
        #1;
        d = rdata_in;
        oe = rdata_oe_in;
        {reg_select_n_out, card_enable_n_out, output_enable_n_out} = 3'b111;
    endtask
endmodule // ccr_host_model

// ==== tb/ccr_bank_monitor.sv ====
// Port checker for the configuration register bank
`timescale 1ns/10ps
module ccr_bank_monitor #(
    parameter int SETTLE_CYC = 40,
    parameter int IRQ_PULSE_CYC = 20
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // Attribute access
    input wire logic reg_select_n_in,
    input wire logic card_enable_n_in,
    input wire logic output_enable_n_in,
    input wire logic write_enable_n_in,
    input wire logic [10:0] addr_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe_out,
    // Card lines
    input wire logic io_mode_out,
    input wire logic card_reset_out,
    input wire logic status_change_line_n_out,
    input wire logic host_irq_line_n_out
);
    logic rd_req, rd_hit, cor_take, prev_we_n, next_prev_we_n;
    assign rd_req = !reg_select_n_in && !card_enable_n_in
        && !output_enable_n_in && write_enable_n_in;
    assign rd_hit = rd_req && (addr_in == 11'h200 || addr_in == 11'h202
        || addr_in == 11'h204);
    assign cor_take = write_enable_n_in && !prev_we_n && !reg_select_n_in
        && !card_enable_n_in && addr_in == 11'h200;
    always_comb next_prev_we_n = write_enable_n_in;
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            prev_we_n <= 1'b1;
        end else begin
            prev_we_n <= next_prev_we_n;
        end
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);
    sequence s_read_pin;
        rd_req && addr_in == 11'h204;
    endsequence
    sequence s_out_of_io;
        !io_mode_out [*3];
    endsequence
    AST_RESET_QUIET: assert property ($fell(reset_in) |-> !data_oe_out
        && !card_reset_out && status_change_line_n_out && !io_mode_out
        && host_irq_line_n_out) else $error("outputs not at reset level");
    AST_READ_DRIVE: assert property (rd_hit |=> data_oe_out)
        else $error("mapped read not driven");
    AST_NO_DRIVE: assert property (!rd_hit |=> !data_oe_out)
        else $error("data driven without mapped read");
    AST_DATA_QUIET: assert property (!data_oe_out
        |-> data_out == 8'h00) else $error("data not zero while released");
    AST_PIN_FIXED: assert property (s_read_pin
        |=> data_out[7:6] == 2'b00 && data_out[3:2] == 2'b11
        && !data_out[0]) else $error("pin bits");
    AST_STATUS_FIXED: assert property (rd_req && addr_in == 11'h202
        |=> data_out[4:3] == 2'b00 && !data_out[0]) else $error("status");
    AST_STS_FALL: assert property ($fell(status_change_line_n_out)
        |-> io_mode_out || $past(io_mode_out)) else $error("status line");
    AST_IRQ_OUT_IO: assert property (s_out_of_io
        |-> host_irq_line_n_out) else $error("irq line low outside io mode");
    AST_CRST_FALL: assert property ($fell(card_reset_out)
        |-> $past(cor_take) || $past(cor_take, 2)) else $error("reset fell");
    AST_CRST_RISE: assert property ($rose(card_reset_out)
        |-> $past(cor_take) || $past(cor_take, 2)) else $error("reset rose");
endmodule // ccr_bank_monitor
bind ccr_bank ccr_bank_monitor #(.SETTLE_CYC(SETTLE_CYC),
    .IRQ_PULSE_CYC(IRQ_PULSE_CYC)) mon (.clock_in, .reset_in,
    .reg_select_n_in, .card_enable_n_in, .output_enable_n_in,
    .write_enable_n_in, .addr_in, .data_out, .data_oe_out, .io_mode_out,
    .card_reset_out, .status_change_line_n_out, .host_irq_line_n_out);

// ==== tb/ccr_bank_bench.sv ====
// Self-checking bench for the configuration register bank
`timescale 1ns/10ps
module ccr_bank_bench;
    logic clock_in, reset_in, reg_select_n_in, card_enable_n_in;
    logic output_enable_n_in, write_enable_n_in, data_oe_out;
    logic [10:0] addr_in, io_addr_in;
    logic [7:0] data_in, data_out, got;
    logic ready_in, irq_request_in, irq_disable_bit_in, idle_in, command_in;
    logic taskfile_hit_out, io_mode_out, card_reset_out, power_save_out;
    logic status_change_line_n_out, host_irq_line_n_out, oe;
    logic [3:0] taskfile_index_out;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    logic [7:0] cfg [8] = '{8'h00, 8'h00, 8'h01, 8'h02, 8'h02, 8'h03,
        8'h03, 8'h04};
    logic [10:0] ioa [8] = '{11'h405, 11'h00c, 11'h30f, 11'h1f3, 11'h3f7,
        11'h376, 11'h1f0, 11'h005};
    logic [7:0] tfx [8] = '{8'h15, 8'h1c, 8'h3f, 8'h33, 8'h3f, 8'h3e,
        8'h20, 8'h00};
    logic [7:0] pw [5] = '{8'h02, 8'h20, 8'h11, 8'h01, 8'h22};
    logic [7:0] pe [5] = '{8'h0e, 8'h0e, 8'h1e, 8'h0e, 8'h2e};
    ccr_bank #(.SETTLE_CYC(12), .IRQ_PULSE_CYC(4)) uut (.clock_in,
        .reset_in, .reg_select_n_in, .card_enable_n_in, .output_enable_n_in,
        .write_enable_n_in, .addr_in, .data_in, .data_out, .data_oe_out,
        .ready_in, .irq_request_in, .irq_disable_bit_in, .idle_in,
        .command_in, .io_addr_in, .taskfile_hit_out, .taskfile_index_out,
        .io_mode_out, .card_reset_out, .power_save_out,
        .status_change_line_n_out, .host_irq_line_n_out);
    ccr_host_model host (.clock_in(clock_in),
        .reg_select_n_out(reg_select_n_in), .addr_out(addr_in),
        .card_enable_n_out(card_enable_n_in), .data_out(data_in),
        .output_enable_n_out(output_enable_n_in), .rdata_in(data_out),
        .write_enable_n_out(write_enable_n_in), .rdata_oe_in(data_oe_out));
    initial begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic rd_chk(input logic [10:0] a, input logic [7:0] e);
        host.rd(a, got, oe);
        chk(8'(oe), 8'h01);
        chk(got, e);
    endtask
    task automatic await(ref logic s, input logic v);
        for (int n = 0; n < 40 && s !== v; n++) begin
            @(posedge clock_in);
            #1;
        end
        chk(8'(s), 8'(v));
    endtask
    task automatic complete_run();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            complete_run();
        end
    end
    initial begin
        {ready_in, irq_request_in, irq_disable_bit_in} = 3'b000;
        {idle_in, command_in} = 2'b00;
        io_addr_in = 11'h000;
        reset_in = 1'b1;
        repeat (10) @(posedge clock_in);
        #1;
        reset_in = 1'b0;
        rd_chk(11'h200, 8'h00);
        rd_chk(11'h202, 8'h00);
        rd_chk(11'h204, 8'h0c);
        host.rd(11'h206, got, oe);
        chk(8'(oe), 8'h00);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            host.wr(11'h200, cfg[i]);
            io_addr_in = ioa[i];
            repeat (3) @(posedge clock_in);
            #1;
            chk({2'b00, io_mode_out, taskfile_hit_out,
                taskfile_hit_out ? taskfile_index_out : 4'h0}, tfx[i]);
            rd_chk(11'h200, cfg[i]);
        end
        $display("test decode done");
        host.wr(11'h200, 8'h00);
        ready_in = 1'b1;
        rd_chk(11'h204, 8'h2e);
        for (int i = 0; i < 5; i++) begin
            host.wr(11'h204, pw[i]);
            rd_chk(11'h204, pe[i]);
        end
        rd_chk(11'h202, 8'h80);
        $display("test pin done");
        host.wr(11'h202, 8'hff);
        rd_chk(11'h202, 8'he4);
        rd_chk(11'h204, 8'h2c);
        await(power_save_out, 1'b1);
        rd_chk(11'h204, 8'h2e);
        host.wr(11'h200, 8'h41);
        await(status_change_line_n_out, 1'b0);
        host.wr(11'h202, 8'h20);
        await(status_change_line_n_out, 1'b1);
        await(power_save_out, 1'b0);
        rd_chk(11'h202, 8'ha0);
        idle_in = 1'b1;
        await(power_save_out, 1'b1);
        command_in = 1'b1;
        await(power_save_out, 1'b0);
        {idle_in, command_in} = 2'b00;
        $display("test status done");
        irq_request_in = 1'b1;
        await(host_irq_line_n_out, 1'b0);
        rd_chk(11'h202, 8'ha2);
        rd_chk(11'h204, 8'h2e);
        irq_disable_bit_in = 1'b1;
        rd_chk(11'h202, 8'ha0);
        {irq_disable_bit_in, irq_request_in} = 2'b00;
        await(host_irq_line_n_out, 1'b1);
        host.wr(11'h200, 8'h01);
        irq_request_in = 1'b1;
        await(host_irq_line_n_out, 1'b0);
        await(host_irq_line_n_out, 1'b1);
        irq_request_in = 1'b0;
        $display("test irq done");
        host.wr(11'h200, 8'h81);
        await(card_reset_out, 1'b1);
        rd_chk(11'h200, 8'h80);
        chk(8'(io_mode_out), 8'h00);
        host.wr(11'h200, 8'h00);
        await(card_reset_out, 1'b0);
        rd_chk(11'h200, 8'h00);
        chk(8'(io_mode_out), 8'h00);
        $display("test soft reset done");
        complete_run();
    end
endmodule // ccr_bank_bench
